// ---- logic/motor_cfg_regs.svh ----
`ifndef MOTOR_CFG_REGS_SVH
`define MOTOR_CFG_REGS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFFSET_BACKEMF_ADVANCE   8'h91
`define OFFSET_STARTUP_BRAKE     8'h92
`define OFFSET_ACCEL_ALIGN       8'h93

// ----------------------------------------
// Reset values and writable masks
// ----------------------------------------
`define RESET_BACKEMF_ADVANCE    16'h0000
`define RESET_STARTUP_BRAKE      16'h0000
`define RESET_ACCEL_ALIGN        16'h0000
`define MASK_BACKEMF_ADVANCE     16'h7fff
`define MASK_STARTUP_BRAKE       16'hffff
`define MASK_ACCEL_ALIGN         16'h7fff

// ----------------------------------------
// Field positions, constant and advance word
// ----------------------------------------
`define POS_EMF_SHIFT            12
`define POS_EMF_SIGNIFICAND      8
`define POS_ADVANCE_MODE         7
`define POS_ADVANCE_SHIFT        4
`define POS_ADVANCE_SIGNIFICAND  0

// ----------------------------------------
// Field positions, start-up word
// ----------------------------------------
`define POS_STATIONARY_THRESHOLD 14
`define POS_BRAKE_CURRENT_SEL    13
`define POS_HYSTERESIS_SEL       12
`define POS_SPEED_DETECT_EN      11
`define POS_REVERSE_EN           10
`define POS_REVERSE_THRESHOLD    8
`define POS_OPEN_LOOP_CURRENT    6
`define POS_CURRENT_RAMP         3
`define POS_BRAKE_TIME           0

// ----------------------------------------
// Field positions, acceleration word
// ----------------------------------------
`define POS_ACCEL_RANGE          14
`define POS_SECOND_ACCEL         11
`define POS_FIRST_ACCEL          8
`define POS_HANDOVER_THRESHOLD   3
`define POS_ALIGN_DURATION       0

// ----------------------------------------
// Timing, stationary window in ms
// ----------------------------------------
`define STATIONARY_BASE_MS       80
`define CLOCK_HZ                 25000000

`endif

// ---- logic/motor_cfg_pkg.sv ----
package motor_cfg_pkg;

  typedef logic [15:0] word_type;

  typedef enum logic [1:0] {
    ACCESS_IDLE  = 2'b00,
    ACCESS_WRITE = 2'b01,
    ACCESS_READ  = 2'b11
  } access_type;

endpackage

// ---- logic/shift_scaler.sv ----
`timescale 1ns/1ps

// ----------------------------------------
// Significand shifted left by a count
// ----------------------------------------
module shift_scaler #(
  parameter int SIG_WIDTH   = 4,
  parameter int SHIFT_WIDTH = 3
) (
  input  wire logic [SIG_WIDTH-1:0]                     significand,
  input  wire logic [SHIFT_WIDTH-1:0]                   shift_count,
  output      logic [SIG_WIDTH+(1<<SHIFT_WIDTH)-2:0]    product
);
  localparam int OUT_WIDTH = SIG_WIDTH + (1 << SHIFT_WIDTH) - 1;

  // Shift counts past four bits would make the product absurdly wide
  if (SIG_WIDTH < 1 || SHIFT_WIDTH < 1 || SHIFT_WIDTH > 4) begin : g_width_check
    $error("shift_scaler: unsupported widths");
  end

  always_comb begin
    product = OUT_WIDTH'(significand) << shift_count;
  end
endmodule

// ---- logic/motor_startup_config_regs.sv ----
`timescale 1ns/1ps
`include "motor_cfg_regs.svh"

// Function
// (R1) Top reserved bit of constant word is held zero; host must not touch it.
// (R2) Back-EMF constant is significand 11:8 shifted left by count 14:12.
// (R3) Advance mode bit 7 picks fixed or supply-ratio-scaled advance time.
// (R4) Advance time is significand 3:0 shifted left by count 6:4.
// (R5) Stationary window 80, 160, 320 or 640 ms by field 15:14.
// (R6) Brake current threshold select: 24 mA clear, 48 mA set.
// (R7) Back-EMF hysteresis select: low clear, high set.
// (R8) Initial speed detection runs only when enable bit 11 is set.
// (R9) Reverse drive allowed only when enable bit 10 is set.
// (R10) Reverse or brake starts at 6.3, 13, 26 or 51 Hz threshold.
// (R11) Open-loop current 0.2, 0.4, 0.8 or 1.6 A by field 7:6.
// (R12) Align current 0.15 to 1.2 A from same open-loop field.
// (R13) Open-loop current ramp rate chosen by field 5:3, slower upward.
// (R14) Brake field 000 disables braking; else time halves from 2.7 s.
// (R15) Acceleration range bit picks fast tables clear, slow set.
// (R16) Handover threshold n*0.8 Hz, or 12.8*(n-16)+11.9 Hz above.
module motor_startup_config_regs #(
  parameter int ADDR_WIDTH = 8
) (
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire logic                  clock_enable,
  input  wire logic                  reg_write,
  input  wire logic                  reg_read,
  input  wire logic [ADDR_WIDTH-1:0] reg_addr,
  input  wire logic [15:0]           reg_wdata,
  output      logic [15:0]           reg_rdata,
  output      logic                  reg_hit,
  output      logic [17:0]           emf_constant,
  output      logic                  advance_mode_select,
  output      logic [17:0]           advance_time,
  output      logic [31:0]           stationary_window_cycles,
  output      logic                  speed_detect_enable,
  output      logic                  brake_current_threshold_select,
  output      logic                  back_emf_hysteresis_select,
  output      logic                  reverse_drive_enable,
  output      logic [1:0]            reverse_drive_threshold,
  output      logic [1:0]            open_loop_current,
  output      logic [1:0]            align_current,
  output      logic [2:0]            open_loop_current_ramp,
  output      logic                  brake_active,
  output      logic [2:0]            brake_time_select,
  output      logic                  accel_range_select,
  output      logic [2:0]            second_order_accel,
  output      logic [2:0]            first_order_accel,
  output      logic                  handover_high_range,
  output      logic [3:0]            handover_step,
  output      logic [2:0]            align_duration
);
  // Shortest stationary window, counted in bank clocks
  localparam logic [31:0] BASE_CYCLES =
    32'((64'(`STATIONARY_BASE_MS) * 64'(`CLOCK_HZ)) / 64'd1000);
  // Four-bit significand shifted by up to seven places
  localparam int PRODUCT_WIDTH = 4 + (1 << 3) - 1;

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  // Offsets are full bytes; a narrower address would alias them
  if (ADDR_WIDTH < 8) begin : g_addr_check
    $error("motor_startup_config_regs: address too narrow");
  end
  // The decode ports must hold the widest shifted product
  if (PRODUCT_WIDTH > 18) begin : g_product_check
    $error("motor_startup_config_regs: product wider than port");
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    motor_cfg_pkg::word_type backemf_and_advance_config_reg;
    motor_cfg_pkg::word_type startup_brake_reverse_config_reg;
    motor_cfg_pkg::word_type acceleration_align_config_reg;
    logic [15:0]             rdata_reg;
    logic                    hit_reg;
  } state_type;

  state_type state_reg;
  state_type state_next;
  motor_cfg_pkg::access_type access;
  logic [ADDR_WIDTH-1:0] addr;
  logic [PRODUCT_WIDTH-1:0] emf_product;
  logic [PRODUCT_WIDTH-1:0] advance_product;

  // ----------------------------------------
  // Register access
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    addr = reg_addr;
    // Write wins when both strobes are high
    access = reg_write ? motor_cfg_pkg::ACCESS_WRITE :
             reg_read  ? motor_cfg_pkg::ACCESS_READ  : motor_cfg_pkg::ACCESS_IDLE;
    state_next.hit_reg = 1'b0;
    case (access)
      motor_cfg_pkg::ACCESS_WRITE: begin
        if (addr == ADDR_WIDTH'(`OFFSET_BACKEMF_ADVANCE)) begin
          // Bit 15 is not storable so it always reads zero [R1]
          state_next.backemf_and_advance_config_reg = reg_wdata & `MASK_BACKEMF_ADVANCE;
          state_next.hit_reg = 1'b1;
        end else if (addr == ADDR_WIDTH'(`OFFSET_STARTUP_BRAKE)) begin
          state_next.startup_brake_reverse_config_reg = reg_wdata & `MASK_STARTUP_BRAKE;
          state_next.hit_reg = 1'b1;
        end else if (addr == ADDR_WIDTH'(`OFFSET_ACCEL_ALIGN)) begin
          state_next.acceleration_align_config_reg = reg_wdata & `MASK_ACCEL_ALIGN;
          state_next.hit_reg = 1'b1;
        end
      end
      motor_cfg_pkg::ACCESS_READ: begin
        // Unmapped reads return zero with no hit
        state_next.rdata_reg = 16'h0000;
        if (addr == ADDR_WIDTH'(`OFFSET_BACKEMF_ADVANCE)) begin
          state_next.rdata_reg = state_reg.backemf_and_advance_config_reg;
          state_next.hit_reg = 1'b1;
        end else if (addr == ADDR_WIDTH'(`OFFSET_STARTUP_BRAKE)) begin
          state_next.rdata_reg = state_reg.startup_brake_reverse_config_reg;
          state_next.hit_reg = 1'b1;
        end else if (addr == ADDR_WIDTH'(`OFFSET_ACCEL_ALIGN)) begin
          state_next.rdata_reg = state_reg.acceleration_align_config_reg;
          state_next.hit_reg = 1'b1;
        end
      end
      default: begin
        state_next.hit_reg = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    // Reset wins over the enable so a frozen bank still clears
    if (rst) begin
      state_reg.backemf_and_advance_config_reg   <= `RESET_BACKEMF_ADVANCE;
      state_reg.startup_brake_reverse_config_reg <= `RESET_STARTUP_BRAKE;
      state_reg.acceleration_align_config_reg    <= `RESET_ACCEL_ALIGN;
      state_reg.rdata_reg                        <= 16'h0000;
      state_reg.hit_reg                          <= 1'b0;
    end else if (clock_enable) begin
      state_reg <= state_next;
    end
  end

  // Read data holds until the next taken read
  assign reg_rdata = state_reg.rdata_reg;
  assign reg_hit   = state_reg.hit_reg;

  // ----------------------------------------
  // Constant and advance decode
  // ----------------------------------------
  shift_scaler #(
    .SIG_WIDTH   (4),
    .SHIFT_WIDTH (3)
  ) emf_scaler (
    .significand (state_reg.backemf_and_advance_config_reg[`POS_EMF_SIGNIFICAND +: 4]),
    .shift_count (state_reg.backemf_and_advance_config_reg[`POS_EMF_SHIFT +: 3]),
    .product     (emf_product)
  ); // [R2]

  shift_scaler #(
    .SIG_WIDTH   (4),
    .SHIFT_WIDTH (3)
  ) advance_scaler (
    .significand (state_reg.backemf_and_advance_config_reg[`POS_ADVANCE_SIGNIFICAND +: 4]),
    .shift_count (state_reg.backemf_and_advance_config_reg[`POS_ADVANCE_SHIFT +: 3]),
    .product     (advance_product)
  ); // [R4]

  // Ports are wider than the product; the upper bits stay zero
  assign emf_constant = 18'(emf_product); // [R2]
  assign advance_time = 18'(advance_product); // [R4]

  // Drive logic scales by supply ratio when set
  assign advance_mode_select =
    state_reg.backemf_and_advance_config_reg[`POS_ADVANCE_MODE]; // [R3]

  // ----------------------------------------
  // Start-up, brake and reverse decode
  // ----------------------------------------
  // Window doubles per code: 80 ms base
  assign stationary_window_cycles = BASE_CYCLES <<
    state_reg.startup_brake_reverse_config_reg[`POS_STATIONARY_THRESHOLD +: 2]; // [R5]
  assign brake_current_threshold_select =
    state_reg.startup_brake_reverse_config_reg[`POS_BRAKE_CURRENT_SEL]; // [R6]
  assign back_emf_hysteresis_select =
    state_reg.startup_brake_reverse_config_reg[`POS_HYSTERESIS_SEL]; // [R7]
  assign speed_detect_enable =
    state_reg.startup_brake_reverse_config_reg[`POS_SPEED_DETECT_EN]; // [R8]
  assign reverse_drive_enable =
    state_reg.startup_brake_reverse_config_reg[`POS_REVERSE_EN]; // [R9]
  assign reverse_drive_threshold =
    state_reg.startup_brake_reverse_config_reg[`POS_REVERSE_THRESHOLD +: 2]; // [R10]
  assign open_loop_current =
    state_reg.startup_brake_reverse_config_reg[`POS_OPEN_LOOP_CURRENT +: 2]; // [R11]
  // Align current tracks the same code at three quarters scale
  assign align_current =
    state_reg.startup_brake_reverse_config_reg[`POS_OPEN_LOOP_CURRENT +: 2]; // [R12]
  assign open_loop_current_ramp =
    state_reg.startup_brake_reverse_config_reg[`POS_CURRENT_RAMP +: 3]; // [R13]
  assign brake_time_select =
    state_reg.startup_brake_reverse_config_reg[`POS_BRAKE_TIME +: 3];
  assign brake_active = |brake_time_select; // [R14]

  // ----------------------------------------
  // Acceleration and align decode
  // ----------------------------------------
  assign accel_range_select =
    state_reg.acceleration_align_config_reg[`POS_ACCEL_RANGE]; // [R15]
  assign second_order_accel =
    state_reg.acceleration_align_config_reg[`POS_SECOND_ACCEL +: 3];
  assign first_order_accel =
    state_reg.acceleration_align_config_reg[`POS_FIRST_ACCEL +: 3];
  // Top bit picks the coarse range; the step is the low four bits
  assign handover_high_range =
    state_reg.acceleration_align_config_reg[`POS_HANDOVER_THRESHOLD + 4]; // [R16]
  assign handover_step =
    state_reg.acceleration_align_config_reg[`POS_HANDOVER_THRESHOLD +: 4]; // [R16]
  assign align_duration =
    state_reg.acceleration_align_config_reg[`POS_ALIGN_DURATION +: 3];
endmodule

// ---- dv/motor_startup_config_regs_props.sv ----
`timescale 1ns/1ps
// ------
// Register bank checks
// ------
module motor_startup_config_regs_props (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        clock_enable,
  input wire logic        reg_write,
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [17:0] emf_constant,
  input wire logic        advance_mode_select,
  input wire logic [17:0] advance_time,
  input wire logic [31:0] stationary_window_cycles,
  input wire logic        speed_detect_enable,
  input wire logic [1:0]  open_loop_current,
  input wire logic [1:0]  align_current,
  input wire logic        brake_active,
  input wire logic [2:0]  brake_time_select
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // A write only counts when the enable lets state advance
  sequence s_wr(logic [7:0] a);
    clock_enable && reg_write && reg_addr == a;
  endsequence
  property p_emf;
    s_wr(8'h91) |=> emf_constant ==
      (18'($past(reg_wdata[11:8])) << $past(reg_wdata[14:12]));
  endproperty
  property p_adv;
    s_wr(8'h91) |=> advance_time ==
      (18'($past(reg_wdata[3:0])) << $past(reg_wdata[6:4]));
  endproperty
  property p_mode;
    s_wr(8'h91) |=> advance_mode_select == $past(reg_wdata[7]);
  endproperty
  property p_win;
    s_wr(8'h92) |=> stationary_window_cycles ==
      (32'd2000000 << $past(reg_wdata[15:14]));
  endproperty
  property p_sde;
    s_wr(8'h92) |=> speed_detect_enable == $past(reg_wdata[11]);
  endproperty
  property p_olc;
    s_wr(8'h92) |=> open_loop_current == $past(reg_wdata[7:6]);
  endproperty
  property p_align;
    s_wr(8'h92) |=> align_current == $past(reg_wdata[7:6]);
  endproperty
  property p_brake;
    s_wr(8'h92) |=> brake_time_select == $past(reg_wdata[2:0]) &&
      brake_active == ($past(reg_wdata[2:0]) != 3'h0);
  endproperty
  a_emf: assert property (p_emf) else $error("constant wrong");
  a_adv: assert property (p_adv) else $error("advance wrong");
  a_mode: assert property (p_mode) else $error("mode wrong");
  a_win: assert property (p_win) else $error("window wrong");
  a_sde: assert property (p_sde) else $error("detect wrong");
  a_olc: assert property (p_olc) else $error("current wrong");
  a_align: assert property (p_align) else $error("align wrong");
  a_brake: assert property (p_brake) else $error("brake wrong");
endmodule

bind motor_startup_config_regs motor_startup_config_regs_props i_props (.*);

// ---- dv/reg_host.sv ----
`timescale 1ns/1ps
// ------
// Host side of the strobe bus
// ------
module reg_host (
  input  wire logic        clock,
  input  wire logic [15:0] reg_rdata,
  input  wire logic        reg_hit,
  output      logic        clock_enable,
  output      logic        reg_write,
  output      logic        reg_read,
  output      logic [7:0]  reg_addr,
  output      logic [15:0] reg_wdata
);
  initial begin
    clock_enable = 1'b1;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
  end
  // One access, taken at the edge after it is driven
  task automatic access(input logic w, input logic ce, input logic [7:0] a,
                        input logic [15:0] d, output logic [15:0] q,
                        output logic h);
    @(posedge clock);
    clock_enable <= ce;
    reg_write <= w;
    reg_read <= !w;
    reg_addr <= a;
    reg_wdata <= (a == 8'h92) ? d : d & 16'h7fff;
    @(posedge clock);
    reg_write <= 1'b0;
    reg_read <= 1'b0;
    clock_enable <= 1'b1;
    // Stale data would hide a missed write
    reg_wdata <= ~reg_wdata;
    #1;
    q = reg_rdata;
    h = reg_hit;
  endtask
endmodule

// ---- dv/motor_startup_config_regs_bench.sv ----
`timescale 1ns/1ps
// ------
// Register bank bench
// ------
module motor_startup_config_regs_bench;
  logic clock, rst, ce, wr, rd, hit, h, sde, bcs, hys, rde, ams, ars, hhr, ba;
  logic [7:0]  addr;
  logic [15:0] wd, rdat, q, v, w;
  logic [17:0] emf, adv;
  logic [31:0] win;
  logic [1:0]  rdt, olc, alc;
  logic [2:0]  ramp, bts, soa, foa, ald;
  logic [3:0]  hst;
  int          fail_count, total_checks;
  motor_startup_config_regs i_motor_startup_config_regs (.clock(clock), .rst(rst),
    .clock_enable(ce), .reg_write(wr), .reg_read(rd), .reg_addr(addr), .reg_wdata(wd),
    .reg_rdata(rdat), .reg_hit(hit), .emf_constant(emf), .advance_mode_select(ams),
    .advance_time(adv), .stationary_window_cycles(win), .speed_detect_enable(sde),
    .brake_current_threshold_select(bcs), .back_emf_hysteresis_select(hys),
    .reverse_drive_enable(rde), .reverse_drive_threshold(rdt), .open_loop_current(olc),
    .align_current(alc), .open_loop_current_ramp(ramp), .brake_active(ba),
    .brake_time_select(bts), .accel_range_select(ars), .second_order_accel(soa),
    .first_order_accel(foa), .handover_high_range(hhr), .handover_step(hst),
    .align_duration(ald));
  reg_host i_reg_host (.clock(clock), .reg_rdata(rdat), .reg_hit(hit),
    .clock_enable(ce), .reg_write(wr), .reg_read(rd), .reg_addr(addr), .reg_wdata(wd));
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic acc(logic iw, logic ice, logic [7:0] a, logic [15:0] d,
                     logic [15:0] e, logic eh);
    i_reg_host.access(iw, ice, a, d, q, h);
    chk("hit", 32'(eh), 32'(h));
    if (!iw && ice) chk("rdata", 32'(e), 32'(q));
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge clock);
    fail_count++;
    print_verdict;
  end
  initial begin
    fail_count = 0;
    total_checks = 0;
    rst = 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    for (int a = 8'h91; a <= 8'h93; a++) acc(1'b0, 1'b1, 8'(a), 16'h0, 16'h0, 1'b1);
    chk("window", 32'd2000000, win);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      v = 16'h5555 * 16'(i);
      w = v & 16'h7fff;
      acc(1'b1, 1'b1, 8'h91, v, 16'h0, 1'b1);
      acc(1'b0, 1'b1, 8'h91, 16'h0, w, 1'b1);
      chk("emf", 32'(w[11:8]) << w[14:12], 32'(emf));
      chk("mode", 32'(w[7]), 32'(ams));
      chk("adv", 32'(w[3:0]) << w[6:4], 32'(adv));
      acc(1'b1, 1'b1, 8'h92, v, 16'h0, 1'b1);
      acc(1'b0, 1'b1, 8'h92, 16'h0, v, 1'b1);
      chk("window", 32'd2000000 << v[15:14], win);
      chk("selects", 32'(v[13:10]), 32'({bcs, hys, sde, rde}));
      chk("codes", 32'(v[9:0]), 32'({rdt, olc, ramp, bts}));
      chk("align", 32'(v[7:6]), 32'(alc));
      acc(1'b1, 1'b1, 8'h93, v, 16'h0, 1'b1);
      acc(1'b0, 1'b1, 8'h93, 16'h0, w, 1'b1);
      chk("accel", 32'(w[14:0]), 32'({ars, soa, foa, hhr, hst, ald}));
    end
    $display("test fields done");
    for (int k = 0; k < 8; k++) begin
      acc(1'b1, 1'b1, 8'h92, 16'(k), 16'h0, 1'b1);
      chk("brake", 32'(k != 0), 32'(ba));
    end
    $display("test brake done");
    acc(1'b1, 1'b1, 8'h94, 16'hffff, 16'h0, 1'b0);
    acc(1'b0, 1'b1, 8'h94, 16'h0, 16'h0, 1'b0);
    acc(1'b0, 1'b1, 8'h90, 16'h0, 16'h0, 1'b0);
    acc(1'b1, 1'b0, 8'h92, 16'h1234, 16'h0, 1'b0);
    acc(1'b0, 1'b1, 8'h92, 16'h0, 16'h0007, 1'b1);
    $display("test refusal done");
    print_verdict;
  end
endmodule
